// ### dv/dspasp_xbus_model.sv
`timescale 1ns/1ns
module dspasp_xbus_model (
   input  wire logic        clk,
   input  wire logic        resetn,
   input  wire logic [15:0] xw_data,
   input  wire logic        xw_stb,
   input  wire logic        xw_macwb,
   input  wire logic [15:0] x_val,
   output logic      [15:0] xr_data,
   output logic      [31:0] stb_cnt,
   output logic      [15:0] last_word,
   output logic             last_wb
);
   assign xr_data = x_val;
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         stb_cnt <= 32'h0;
         last_word <= 16'h0;
         last_wb <= 1'b0;
      end
      else if (xw_stb)
      begin
         stb_cnt <= stb_cnt + 32'h1;
         last_word <= xw_data;
         last_wb <= xw_macwb;
      end
   end
endmodule // dspasp_xbus_model

// ### dv/tb_top.sv
`timescale 1ns/1ns
module tb_top;
   import dspasp_pkg::*;
   logic        CLK, RESETN, AVS_READ, AVS_WRITE, AVS_WAITREQUEST, XW_STB, XW_MACWB;
   logic [5:0]  AVS_ADDRESS;
   logic [31:0] AVS_WRITEDATA, AVS_READDATA, stb_cnt;
   logic [3:0]  AVS_BYTEENABLE;
   logic [15:0] XR_DATA, XW_DATA, x_val, last_word;
   logic        last_wb;
   logic [39:0] acc_a, acc_b;
   logic [55:0] sh_last;
   int          n_fail, total_checks, seed;
   localparam logic [29:0] ZERO_ADDR = {6'h3C, 6'h2C, OFF_SHIFT, OFF_STORE, OFF_CTRL};

   dspasp_top DUT (.CLK(CLK), .RESETN(RESETN), .AVS_ADDRESS(AVS_ADDRESS),
      .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
      .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_READDATA(AVS_READDATA),
      .AVS_WAITREQUEST(AVS_WAITREQUEST), .XR_DATA(XR_DATA), .XW_DATA(XW_DATA),
      .XW_STB(XW_STB), .XW_MACWB(XW_MACWB));
   dspasp_xbus_model xbm (.clk(CLK), .resetn(RESETN), .xw_data(XW_DATA), .xw_stb(XW_STB),
      .xw_macwb(XW_MACWB), .x_val(x_val), .xr_data(XR_DATA), .stb_cnt(stb_cnt),
      .last_word(last_word), .last_wb(last_wb));

   initial
   begin
      CLK = 1'b0;
      forever #5 CLK = ~CLK;
   end

   task automatic finish_test();
      if (n_fail == 0 && total_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Holds the request until waitrequest is sampled low
   task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d,
                      input logic [3:0] be, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge CLK);
      AVS_ADDRESS <= a;
      AVS_WRITEDATA <= d;
      AVS_BYTEENABLE <= be;
      AVS_WRITE <= w;
      AVS_READ <= !w;
      do
      begin
         @(posedge CLK);
         n++;
      end
      while (AVS_WAITREQUEST !== 1'b0 && n < 20);
      if (n >= 20)
         chk(1'b1, 1'b0);
      q = AVS_READDATA;
      AVS_WRITE <= 1'b0;
      AVS_READ <= 1'b0;
   endtask

   task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [3:0] be);
      logic [31:0] q;
      bus(1'b1, a, d, be, q);
   endtask

   task automatic rd(input logic [5:0] a, output logic [31:0] q);
      bus(1'b0, a, 32'h0, 4'hF, q);
   endtask

   function automatic logic [16:0] exp_store(logic [39:0] acc, logic [1:0] ctrl, logic do_round);
      logic inc;
      logic signed [24:0] r;
      inc = do_round & acc[15] & (ctrl[0] | (acc[15:0] != 16'h8000) | acc[16]);
      r = {acc[39], acc[39:16]} + {24'h0, inc};
      if (ctrl[1] && !acc[39] && r > 25'sh007FFF)
         return {1'b1, 16'h7FFF};
      if (ctrl[1] && acc[39] && r < -25'sh008000)
         return {1'b1, 16'h8000};
      return {1'b0, r[15:0]};
   endfunction

   function automatic logic [55:0] exp_shift(logic [1:0] src, logic [5:0] amt, logic lg,
                                             logic [15:0] x);
      logic [39:0] op, r;
      logic fill;
      int n;
      n = $signed(amt);
      if (n < 0)
         n = -n;
      if (n > 16)
         n = 16;
      fill = !lg & x[15];
      op = amt[5] ? {{24{fill}}, x} : {{8{fill}}, x, 16'h0};
      if (src == 2'h0)
         op = acc_a;
      if (src == 2'h1)
         op = acc_b;
      if (amt[5])
         r = op << n;
      else if (lg)
         r = op >> n;
      else
         r = $signed(op) >>> n;
      return {amt[5] ? r[15:0] : r[31:16], r};
   endfunction

   task automatic do_store(input logic [39:0] a, input logic [39:0] b, input logic [1:0] ctrl,
                           input logic [1:0] op, input logic tgt);
      logic [16:0] e;
      logic [31:0] d, c0;
      acc_a = a;
      acc_b = b;
      wr(OFF_ACCA_LO, a[31:0], 4'hF);
      wr(OFF_ACCA_HI, {24'h0, a[39:32]}, 4'hF);
      wr(OFF_ACCB_LO, b[31:0], 4'hF);
      wr(OFF_ACCB_HI, {24'h0, b[39:32]}, 4'hF);
      wr(OFF_CTRL, {30'h0, ctrl}, 4'h1);
      wr(OFF_STATUS, 32'h0007_0000, 4'h4);
      e = exp_store(((op == 2'h2) ^ tgt) ? b : a, ctrl, op != 2'h0);
      c0 = stb_cnt;
      wr(OFF_STORE, {29'h0, tgt, op}, 4'hF);
      repeat (3) @(posedge CLK);
      chk(stb_cnt, c0 + 32'(op != 2'h3));
      if (op != 2'h3)
      begin
         chk(last_word, e[15:0]);
         chk(last_wb, op == 2'h2);
         rd(OFF_STATUS, d);
         chk(d[16:0], e);
      end
      rd(OFF_ACCA_LO, d);
      chk(d, a[31:0]);
   endtask

   task automatic do_shift(input logic [1:0] src, input logic [5:0] amt, input logic lg,
                           input logic [15:0] x);
      logic [55:0] e;
      logic [31:0] lo, hi, m;
      x_val <= x;
      wr(OFF_SHIFT, {21'h0, lg, src, 2'h0, amt}, 4'hF);
      rd(OFF_SHRES_LO, lo);
      rd(OFF_SHRES_HI, hi);
      rd(OFF_SHRES16, m);
      // Source 3 is ignored, so the old results must stand
      e = (src == 2'h3) ? sh_last : exp_shift(src, amt, lg, x);
      sh_last = e;
      chk({hi[7:0], lo}, e[39:0]);
      chk(m[15:0], e[55:40]);
   endtask

   initial
   begin
      #300000;
      n_fail++;
      finish_test();
   end

   initial
   begin
      logic [31:0] q;
      logic [39:0] a, b;
      seed = 865;
      n_fail = 0;
      total_checks = 0;
      RESETN = 1'b0;
      {AVS_READ, AVS_WRITE, AVS_ADDRESS, AVS_WRITEDATA, AVS_BYTEENABLE} = '0;
      x_val = 16'h0;
      acc_a = '0;
      acc_b = '0;
      sh_last = '0;
      repeat (5) @(posedge CLK);
      RESETN <= 1'b1;
      @(posedge CLK);
      chk(AVS_WAITREQUEST, 1'b1);
      chk(AVS_READDATA, 32'h0);
      chk({XW_STB, XW_MACWB, XW_DATA}, 18'h0);
      // Unmapped write must leave control, store, shift and unmapped offsets reading zero
      wr(6'h3C, 32'hFFFF_FFFF, 4'hF);
      for (int i = 0; i < 5; i++)
      begin
         rd(ZERO_ADDR[6*i +: 6], q);
         chk(q, 32'h0);
      end
      // Rounding ties, carries and saturation edges in every mode
      for (int m = 0; m < 4; m++)
      begin
         do_store(40'h00_1234_8000, 40'h00_1235_8000, 2'(m), 2'h1, 1'b0);
         do_store(40'h00_1234_8000, 40'h00_1235_8000, 2'(m), 2'h1, 1'b1);
         do_store(40'h00_7FFF_8000, 40'hFF_7FFF_0000, 2'(m), 2'h1, 1'b0);
         do_store(40'h00_7FFF_8000, 40'hFF_7FFF_0000, 2'(m), 2'h0, 1'b1);
         do_store(40'hFF_8000_FFFF, 40'h01_0000_0000, 2'(m), 2'h2, 1'b1);
         do_store(40'h00_0001_7FFF, 40'hFF_8000_0000, 2'(m), 2'h2, 1'b0);
      end
      do_store(40'h00_1111_8000, 40'h0, 2'h0, 2'h3, 1'b0);
      for (int i = 0; i < 100; i++)
      begin
         a = 40'({$random(seed), $random(seed)});
         b = 40'({$random(seed), $random(seed)});
         if (a[33])
            a[39:32] = {8{a[31]}};
         do_store(a, b, 2'($random(seed)), 2'($unsigned($random(seed)) % 3), 1'($random(seed)));
      end
      for (int s = 0; s < 3; s++)
      begin
         do_shift(2'(s), 6'h00, 1'b0, 16'h8001);
         do_shift(2'(s), 6'h10, 1'b0, 16'h8001);
         do_shift(2'(s), 6'h30, 1'b1, 16'hC003);
         do_shift(2'(s), 6'h1F, 1'b0, 16'hF0F0);
         do_shift(2'(s), 6'h20, 1'b0, 16'h7001);
      end
      for (int i = 0; i < 100; i++)
         do_shift(2'($unsigned($random(seed)) % 3), 6'($random(seed)), 1'($random(seed)),
                  16'($random(seed)));
      do_shift(2'h3, 6'h04, 1'b0, 16'h1234);
      finish_test();
   end
endmodule // tb_top

// ### rtl/dspasp_pkg.sv
// Operation
// - Round stage is combinational, result in the same cycle as the store
// - round_mode_select in core_control_reg picks biased or convergent rounding
// - Round stage hands a 16-bit 1.15 word to write saturation
// - No rounding: store accumulator bits 31..16, drop the low word
// - Conventional: add bit 15 zero-extended to bits 31..16
// - Convergent: low word 0x8000 increments only when bit 16 is one
// - Truncated and rounded accumulator stores go out the X bus via saturation
// - Multiply-accumulate write-back is always rounded, to combined X/Y space
// - Write saturation never alters the source accumulator
// - Saturation uses rounded word, accumulator overflow and round adder overflow
// - Saturation enabled: values above 0x007FFF become 0x7FFF
// - Saturation enabled: values below 0xFF8000 become 0x8000
// - Accumulator bit 39 is the operand sign for the saturation test
// - Saturation disabled: round output passes unaltered
// - Shifter does arithmetic/logical right or left shifts to 16 in one cycle
// - Shift operand is accumulator A, accumulator B or X bus data
// - Signed amount: positive right, negative left, zero unchanged
// - 40-bit shifter, 40-bit DSP result and 16-bit MCU result
// - X data sits at positions 16..31 for right, 0..15 for left
// - Write-back stores rounded high word of the non-target accumulator
package dspasp_pkg;
   localparam int ACC_W = 40;
   localparam int ADDR_W = 6;
   localparam logic [5:0] OFF_CTRL = 6'h00;
   localparam logic [5:0] OFF_ACCA_LO = 6'h04;
   localparam logic [5:0] OFF_ACCA_HI = 6'h08;
   localparam logic [5:0] OFF_ACCB_LO = 6'h0C;
   localparam logic [5:0] OFF_ACCB_HI = 6'h10;
   localparam logic [5:0] OFF_STORE = 6'h14;
   localparam logic [5:0] OFF_STATUS = 6'h18;
   localparam logic [5:0] OFF_SHIFT = 6'h1C;
   localparam logic [5:0] OFF_SHRES_LO = 6'h20;
   localparam logic [5:0] OFF_SHRES_HI = 6'h24;
   localparam logic [5:0] OFF_SHRES16 = 6'h28;
   localparam int CTRL_ROUND_MODE_BIT = 0;
   localparam int CTRL_SAT_EN_BIT = 1;
   localparam int STO_OP_LSB = 0;
   localparam int STO_TGT_BIT = 2;
   localparam int STAT_WORD_LSB = 0;
   localparam int STAT_SAT_BIT = 16;
   localparam int STAT_ADD_BIT = 17;
   localparam int STAT_SRC_BIT = 18;
   localparam int SH_AMT_LSB = 0;
   localparam int SH_SRC_LSB = 8;
   localparam int SH_LOGIC_BIT = 10;
   localparam logic CTRL_ROUND_MODE_RST = 1'b0;
   localparam logic CTRL_SAT_EN_RST = 1'b0;
   localparam logic [15:0] HALF_LSW = 16'h8000;
   localparam logic [15:0] SAT_POS = 16'h7FFF;
   localparam logic [15:0] SAT_NEG = 16'h8000;
   localparam logic [23:0] SAT_HI_LIM = 24'h007FFF;
   localparam logic [23:0] SAT_LO_LIM = 24'hFF8000;
   localparam logic [5:0] SHIFT_MAX = 6'h10;

   typedef enum logic [0:0] {BUS_ACK = 1'b0, BUS_WAIT = 1'b1} dspasp_bus_e;
   typedef enum logic [1:0] {
      SOP_TRUNC = 2'h0,
      SOP_ROUND = 2'h1,
      SOP_MACWB = 2'h2,
      SOP_NONE  = 2'h3
   } dspasp_sop_e;
   typedef enum logic [1:0] {
      SRC_ACCA = 2'h0,
      SRC_ACCB = 2'h1,
      SRC_XBUS = 2'h2,
      SRC_NONE = 2'h3
   } dspasp_src_e;

   function automatic logic [39:0] pick_acc(input logic [39:0] a,
                                            input logic [39:0] b,
                                            input logic        sel_b);
      pick_acc = sel_b ? b : a;
   endfunction

   function automatic logic [31:0] merge_be(input logic [31:0] old,
                                            input logic [31:0] nw,
                                            input logic [3:0]  be);
      for (int i = 0; i < 4; i++)
      begin
         merge_be[8*i +: 8] = be[i] ? nw[8*i +: 8] : old[8*i +: 8];
      end
   endfunction
endpackage

// ### rtl/dspasp_round.sv
`timescale 1ns/1ns
module dspasp_round (
   input  wire logic [39:0] acc,
   input  wire logic        round_en,
   input  wire logic        conv,
   input  wire logic        sat_en,
   output logic      [15:0] round_word,
   output logic      [24:0] wide,
   output logic             add_ovf,
   output logic             src_ovf,
   output logic             sat_hit,
   output logic      [15:0] mem_word
);
   import dspasp_pkg::*;
   logic inc;
   logic pos;
   logic neg;
   always_comb
   begin
      inc = 1'b0;
      if (round_en)
      begin
         if (conv && acc[15:0] == HALF_LSW)
            inc = acc[16];
         else
            inc = acc[15];
      end
      round_word = acc[31:16] + {15'h0000, inc};
      wide = {acc[39], acc[39:16]} + {24'h000000, inc};
      add_ovf = inc && (acc[31:16] == SAT_POS);
      src_ovf = (|acc[39:31]) && !(&acc[39:31]);
      pos = !acc[39] && (src_ovf || add_ovf);
      neg = acc[39] && ($signed(wide) < $signed({SAT_LO_LIM[23], SAT_LO_LIM}));
      sat_hit = sat_en && (pos || neg);
      mem_word = round_word;
      if (sat_en && pos)
         mem_word = SAT_POS;
      else if (sat_en && neg)
         mem_word = SAT_NEG;
   end
endmodule // dspasp_round

// ### rtl/dspasp_shift.sv
`timescale 1ns/1ns
module dspasp_shift (
   input  wire logic [39:0] opnd,
   input  wire logic [5:0]  amt,
   input  wire logic        logic_sh,
   output logic      [39:0] res
);
   import dspasp_pkg::*;
   logic [5:0] mag;
   always_comb
   begin
      mag = amt[5] ? 6'(-amt) : amt;
      if (mag > SHIFT_MAX)
         mag = SHIFT_MAX;
      if (amt[5])
         res = opnd << mag;
      else if (logic_sh)
         res = opnd >> mag;
      else
         res = 40'($signed(opnd) >>> mag);
   end
endmodule // dspasp_shift

// ### rtl/dspasp_top.sv
// Design decisions made here: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ns
module dspasp_top (
   input  wire logic                         CLK,
   input  wire logic                         RESETN,
   input  wire logic [dspasp_pkg::ADDR_W-1:0] AVS_ADDRESS,
   input  wire logic                         AVS_READ,
   input  wire logic                         AVS_WRITE,
   input  wire logic [31:0]                  AVS_WRITEDATA,
   input  wire logic [3:0]                   AVS_BYTEENABLE,
   output logic      [31:0]                  AVS_READDATA,
   output logic                              AVS_WAITREQUEST,
   input  wire logic [15:0]                  XR_DATA,
   output logic      [15:0]                  XW_DATA,
   output logic                              XW_STB,
   output logic                              XW_MACWB
);
   import dspasp_pkg::*;

   typedef struct packed {
      dspasp_bus_e bus;
      logic [31:0] rdata;
      logic        round_mode_select;
      logic        data_write_sat_enable;
      logic [39:0] acca;
      logic [39:0] accb;
      logic [15:0] xw_data;
      logic        xw_stb;
      logic        xw_macwb;
      logic [15:0] st_word;
      logic        st_sat;
      logic        st_add;
      logic        st_src;
      logic [39:0] sh_res;
      logic [15:0] sh_res16;
   } dspasp_top_s;

   dspasp_top_s q;
   dspasp_top_s d;

   logic        take;
   logic        wr_go;
   logic        st_go;
   logic        sh_go;
   dspasp_sop_e sop;
   logic        sel_b;
   logic [39:0] st_acc;
   logic        round_en;
   logic [15:0] round_word;
   logic [24:0] wide;
   logic        add_ovf;
   logic        src_ovf;
   logic        sat_hit;
   logic [15:0] mem_word;
   dspasp_src_e sh_src;
   logic [5:0]  sh_amt;
   logic        sh_lg;
   logic [15:0] xfill;
   logic [39:0] sh_opnd;
   logic [39:0] sh_out;
   logic [31:0] rd;
   logic [31:0] hi_a;
   logic [31:0] hi_b;

   // A transfer completes on the cycle the slave shows waitrequest low
   assign take = q.bus == BUS_ACK;
   assign wr_go = AVS_WRITE && take;
   assign st_go = wr_go && AVS_ADDRESS == OFF_STORE;
   assign sh_go = wr_go && AVS_ADDRESS == OFF_SHIFT;

   assign sop = dspasp_sop_e'(AVS_WRITEDATA[STO_OP_LSB +: 2]);
   assign sel_b = AVS_WRITEDATA[STO_TGT_BIT] ^ (sop == SOP_MACWB);
   assign st_acc = pick_acc(q.acca, q.accb, sel_b);
   assign round_en = sop != SOP_TRUNC;

   dspasp_round u_round (
      .acc        (st_acc),
      .round_en   (round_en),
      .conv       (!q.round_mode_select),
      .sat_en     (q.data_write_sat_enable),
      .round_word (round_word),
      .wide       (wide),
      .add_ovf    (add_ovf),
      .src_ovf    (src_ovf),
      .sat_hit    (sat_hit),
      .mem_word   (mem_word)
   );

   assign sh_src = dspasp_src_e'(AVS_WRITEDATA[SH_SRC_LSB +: 2]);
   assign sh_amt = AVS_WRITEDATA[SH_AMT_LSB +: 6];
   assign sh_lg = AVS_WRITEDATA[SH_LOGIC_BIT];
   assign xfill = {16{XR_DATA[15] && !sh_lg}};

   always_comb
   begin
      case (sh_src)
         SRC_ACCA:
            sh_opnd = q.acca;
         SRC_ACCB:
            sh_opnd = q.accb;
         SRC_XBUS:
         begin
            if (sh_amt[5])
               sh_opnd = {xfill[7:0], xfill, XR_DATA};
            else
               sh_opnd = {xfill[7:0], XR_DATA, 16'h0000};
         end
         default:
            sh_opnd = 40'h0000000000;
      endcase
   end

   dspasp_shift u_shift (
      .opnd     (sh_opnd),
      .amt      (sh_amt),
      .logic_sh (sh_lg),
      .res      (sh_out)
   );

   assign hi_a = {24'h000000, q.acca[39:32]};
   assign hi_b = {24'h000000, q.accb[39:32]};

   always_comb
   begin
      case (AVS_ADDRESS)
         OFF_CTRL:
            rd = {30'h00000000, q.data_write_sat_enable, q.round_mode_select};
         OFF_ACCA_LO:
            rd = q.acca[31:0];
         OFF_ACCA_HI:
            rd = hi_a;
         OFF_ACCB_LO:
            rd = q.accb[31:0];
         OFF_ACCB_HI:
            rd = hi_b;
         OFF_STATUS:
            rd = {13'h0000, q.st_src, q.st_add, q.st_sat, q.st_word};
         OFF_SHRES_LO:
            rd = q.sh_res[31:0];
         OFF_SHRES_HI:
            rd = {24'h000000, q.sh_res[39:32]};
         OFF_SHRES16:
            rd = {16'h0000, q.sh_res16};
         default:
            rd = 32'h00000000;
      endcase
   end

   always_comb
   begin
      logic [31:0] m;
      m = 32'h00000000;
      d = q;
      d.xw_stb = 1'b0;
      d.xw_macwb = 1'b0;
      if ((AVS_READ || AVS_WRITE) && q.bus == BUS_WAIT)
      begin
         d.bus = BUS_ACK;
         if (AVS_READ)
            d.rdata = rd;
      end
      else
      begin
         d.bus = BUS_WAIT;
      end
      if (wr_go)
      begin
         case (AVS_ADDRESS)
            OFF_CTRL:
            begin
               if (AVS_BYTEENABLE[0])
               begin
                  d.round_mode_select = AVS_WRITEDATA[CTRL_ROUND_MODE_BIT];
                  d.data_write_sat_enable = AVS_WRITEDATA[CTRL_SAT_EN_BIT];
               end
            end
            OFF_ACCA_LO:
               d.acca[31:0] = merge_be(q.acca[31:0], AVS_WRITEDATA, AVS_BYTEENABLE);
            OFF_ACCA_HI:
            begin
               m = merge_be(hi_a, AVS_WRITEDATA, AVS_BYTEENABLE);
               d.acca[39:32] = m[7:0];
            end
            OFF_ACCB_LO:
               d.accb[31:0] = merge_be(q.accb[31:0], AVS_WRITEDATA, AVS_BYTEENABLE);
            OFF_ACCB_HI:
            begin
               m = merge_be(hi_b, AVS_WRITEDATA, AVS_BYTEENABLE);
               d.accb[39:32] = m[7:0];
            end
            OFF_STATUS:
            begin
               // Write one clears a sticky flag
               if (AVS_BYTEENABLE[2])
               begin
                  d.st_sat = q.st_sat && !AVS_WRITEDATA[STAT_SAT_BIT];
                  d.st_add = q.st_add && !AVS_WRITEDATA[STAT_ADD_BIT];
                  d.st_src = q.st_src && !AVS_WRITEDATA[STAT_SRC_BIT];
               end
            end
            OFF_STORE:
            begin
               if (sop != SOP_NONE)
               begin
                  d.xw_data = mem_word;
                  d.xw_stb = 1'b1;
                  d.xw_macwb = sop == SOP_MACWB;
                  d.st_word = mem_word;
                  // Sticky flags, setting wins over clearing
                  d.st_sat = q.st_sat || sat_hit;
                  d.st_add = q.st_add || add_ovf;
                  d.st_src = q.st_src || src_ovf;
               end
            end
            OFF_SHIFT:
            begin
               if (sh_src != SRC_NONE)
               begin
                  d.sh_res = sh_out;
                  d.sh_res16 = sh_amt[5] ? sh_out[15:0] : sh_out[31:16];
               end
            end
            default:
            begin
               d.sh_res = q.sh_res;
            end
         endcase
      end
   end

   always_ff @(posedge CLK)
   begin
      if (!RESETN)
         q <= '{bus: BUS_WAIT, round_mode_select: CTRL_ROUND_MODE_RST,
                data_write_sat_enable: CTRL_SAT_EN_RST, default: '0};
      else
         q <= d;
   end

   assign AVS_READDATA = q.rdata;
   assign AVS_WAITREQUEST = q.bus;
   assign XW_DATA = q.xw_data;
   assign XW_STB = q.xw_stb;
   assign XW_MACWB = q.xw_macwb;

   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RESETN);

   property p_bus_ack;
      (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST ##1 AVS_WAITREQUEST;
   endproperty
   a_bus_ack: assert property (p_bus_ack) else $error("waitrequest not one wait state");

   property p_store_out;
      st_go && sop != SOP_NONE |=> XW_STB && XW_DATA == $past(mem_word);
   endproperty
   a_store_out: assert property (p_store_out) else $error("store word not issued");

   property p_trunc;
      st_go && sop == SOP_TRUNC && !q.data_write_sat_enable |=> XW_DATA == $past(st_acc[31:16]);
   endproperty
   a_trunc: assert property (p_trunc) else $error("truncated store wrong");

   property p_conv;
      round_en && q.round_mode_select |-> round_word == st_acc[31:16] + {15'h0000, st_acc[15]};
   endproperty
   a_conv: assert property (p_conv) else $error("conventional round wrong");

   property p_tie;
      round_en && !q.round_mode_select && st_acc[15:0] == HALF_LSW
         |-> round_word == st_acc[31:16] + {15'h0000, st_acc[16]};
   endproperty
   a_tie: assert property (p_tie) else $error("convergent tie wrong");

   property p_macwb;
      st_go && sop == SOP_MACWB |-> round_en ##1 XW_MACWB && XW_STB;
   endproperty
   a_macwb: assert property (p_macwb) else $error("write-back not rounded");

   property p_keep;
      st_go |=> q.acca == $past(q.acca) && q.accb == $past(q.accb);
   endproperty
   a_keep: assert property (p_keep) else $error("store altered accumulator");

   property p_sat_pos;
      q.data_write_sat_enable && !st_acc[39] && $signed(wide) > $signed({1'b0, SAT_HI_LIM})
         |-> mem_word == SAT_POS;
   endproperty
   a_sat_pos: assert property (p_sat_pos) else $error("positive clamp missing");

   property p_sat_neg;
      q.data_write_sat_enable && st_acc[39] && $signed(wide) < $signed({1'b1, SAT_LO_LIM})
         |-> mem_word == SAT_NEG;
   endproperty
   a_sat_neg: assert property (p_sat_neg) else $error("negative clamp missing");

   property p_nosat;
      !q.data_write_sat_enable |-> mem_word == round_word;
   endproperty
   a_nosat: assert property (p_nosat) else $error("unsaturated word altered");

   property p_zero;
      sh_go && sh_amt == 6'h00 && sh_src != SRC_NONE |=> q.sh_res == $past(sh_opnd);
   endproperty
   a_zero: assert property (p_zero) else $error("zero shift changed operand");

   property p_round_carry;
      q.data_write_sat_enable && round_en && st_acc[39:16] == 24'h007FFF && st_acc[15]
         |-> mem_word == SAT_POS;
   endproperty
   a_round_carry: assert property (p_round_carry) else $error("round carry not clamped");

   property p_neg_sign;
      st_acc[39] |-> mem_word == SAT_NEG || mem_word == round_word;
   endproperty
   a_neg_sign: assert property (p_neg_sign) else $error("negative operand clamped high");

   property p_wb_src;
      st_go && sop == SOP_MACWB && !AVS_WRITEDATA[STO_TGT_BIT] |-> st_acc == q.accb;
   endproperty
   a_wb_src: assert property (p_wb_src) else $error("write-back source wrong");

   property p_src_flag;
      st_go && sop != SOP_NONE && src_ovf |=> q.st_src;
   endproperty
   a_src_flag: assert property (p_src_flag) else $error("source overflow not recorded");

endmodule // dspasp_top
